// file: rtl/wcs_top.sv
// wcs_top: word clock reference select, qualification, regeneration and output
// assumes an APB master on clk_sys and an unsynchronised word clock pin
//
// Contract
// - word clock used only if preferred, auto, valid
// - accept single, double, quad rates automatically
// - lock indicator lit and status reported
// - output word clock always running
// - master mode uses host requested rate
// - slave mode output follows input frequency
// - reference lost: master at 44.1 kHz if last reference below about 46 kHz, else 48 kHz
// - single-speed option keeps output 32-48 kHz
// - slaved output phase aligned to input
// - regenerate fast clock, jitter rejected
// - measure reference frequency, report source
`timescale 1ns/1ps
module wcs_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wc_in,
  output logic wc_out,
  output logic fast_clk_out,
  output logic word_clock_lock_indicator
);
  // ===================================================================
  // declarations
  logic wc_s1_r;
  logic wc_s2_r;
  logic rise;
  wcs_pkg::wcs_det_t det;
  logic [31:0] ctrl_r;
  logic [31:0] rate_r;
  logic automatic_sync_mode;
  logic pref_wc;
  logic single_speed;
  logic use_wc;
  wcs_pkg::wcs_src_t active_sync_source_display;
  logic [wcs_pkg::CNT_W-1:0] ref_per;
  logic [wcs_pkg::CNT_W-1:0] avg_per_r;
  logic [wcs_pkg::CNT_W+2:0] hold_per;
  logic [1:0] sub_mask;
  logic realign;
  logic wrap;
  logic [wcs_pkg::CNT_W+9:0] nco_sum;
  logic nco_wrap;
  logic nco_sat;
  logic sel_ctrl;
  logic sel_rate;
  logic sel_stat;
  logic sel_freq;
  logic wr_ctrl;
  logic wr_rate;
  logic [31:0] stat_word;
  logic [31:0] freq_word;
  logic [1:0] div_sel;
  logic [wcs_pkg::CNT_W+1:0] out_per;
  logic [wcs_pkg::CNT_W+1:0] phase_r;
  logic [1:0] sub_r;
  logic wc_out_r;
  logic fast_r;
  logic [wcs_pkg::CNT_W+9:0] nco_r;
  logic [wcs_pkg::CNT_W-1:0] fb_per;
  logic [wcs_pkg::CNT_W-1:0] master_per;
  logic [wcs_pkg::CNT_W-1:0] host_per;
  logic wr_en;
  logic rd_en;
  logic adr_hit;
  logic [31:0] rd_mux;
  logic lost_r;
  logic was_wc_r;

  // ===================================================================
  // two-flop synchroniser for the word clock pin
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wc_s1_r <= 1'b0;
      wc_s2_r <= 1'b0;
    end else begin
      wc_s1_r <= wc_in;
      wc_s2_r <= wc_s1_r;
    end
  end

  // period measurement and qualification
  wcs_period_det u_det (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wc_sync(wc_s2_r),
    .rise(rise),
    .det(det)
  );

  // ===================================================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // address decode, one wire per register
  assign sel_ctrl = (paddr == wcs_pkg::ADR_CTRL);
  assign sel_rate = (paddr == wcs_pkg::ADR_RATE);
  assign sel_stat = (paddr == wcs_pkg::ADR_STAT);
  assign sel_freq = (paddr == wcs_pkg::ADR_FREQ);
  assign adr_hit = sel_ctrl | sel_rate | sel_stat | sel_freq;
  assign wr_ctrl = wr_en & sel_ctrl;
  assign wr_rate = wr_en & sel_rate;
  assign pslverr = psel & penable & ~adr_hit; // unmapped: error, write dropped

  // status and frequency words
  assign stat_word = {28'h0, lost_r, 1'b0,
                      active_sync_source_display == wcs_pkg::WCS_SRC_WC, det.valid};
  assign freq_word = {16'h0, ref_per};

  // read select; unmapped reads return zero
  assign rd_mux = sel_ctrl ? ctrl_r :
                  sel_rate ? rate_r :
                  sel_stat ? stat_word :
                  sel_freq ? freq_word :
                  32'h0000_0000;

  // control and host rate registers; read data registered
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_r <= wcs_pkg::CTRL_RST;
      rate_r <= wcs_pkg::RATE_RST;
      prdata <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {29'h0, pwdata[2:0]};
      end
      if (wr_rate) begin
        rate_r <= {15'h0, pwdata[16:0]};
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ===================================================================
  // reference selection
  assign automatic_sync_mode = ctrl_r[wcs_pkg::CTRL_AUTO];
  assign pref_wc = ctrl_r[wcs_pkg::CTRL_PREF_WC];
  assign single_speed = ctrl_r[wcs_pkg::CTRL_SS];
  assign use_wc = pref_wc & automatic_sync_mode & det.valid;
  assign active_sync_source_display = use_wc ? wcs_pkg::WCS_SRC_WC : wcs_pkg::WCS_SRC_INT;
  assign word_clock_lock_indicator = det.valid;

  // host rate in hertz to period in cycles; only used in master mode
  assign host_per = (rate_r[16:0] == 17'h0) ? wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / wcs_pkg::FS_48_HZ) :
                    wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / rate_r[16:0]);

  // fallback: 44.1 kHz if the last good reference period is longer than about 46 kHz, else 48 kHz
  assign fb_per = (avg_per_r > wcs_pkg::CNT_W'(wcs_pkg::PER_FAM_CYC)) ?
                  wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / wcs_pkg::FS_441_HZ) :
                  wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / wcs_pkg::FS_48_HZ);
  assign master_per = lost_r ? fb_per : host_per;

  // lost flag: reference dropped while it was in use, cleared when the word clock is selected again (use_wc) or by a rate write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      was_wc_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      was_wc_r <= use_wc;
      if (was_wc_r && !use_wc) begin
        lost_r <= 1'b1;
      end else if (use_wc || wr_rate) begin
        lost_r <= 1'b0;
      end
    end
  end

  // smoothed reference period, first-order low pass rejects edge jitter
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      avg_per_r <= wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / wcs_pkg::FS_48_HZ);
    end else if (rise && use_wc) begin
      avg_per_r <= avg_per_r - (avg_per_r >> 3) + (det.period >> 3);
    end
  end

  // ===================================================================
  // output word clock: period source and single-speed divide
  assign ref_per = use_wc ? avg_per_r : master_per;
  assign div_sel = !single_speed ? 2'd0 :
                   (ref_per < wcs_pkg::CNT_W'(wcs_pkg::PER_SS_CYC / 2)) ? 2'd2 :
                   (ref_per < wcs_pkg::CNT_W'(wcs_pkg::PER_SS_CYC)) ? 2'd1 : 2'd0;
  assign out_per = {2'b00, ref_per} << div_sel;

  // realign only on every first of 1, 2 or 4 input edges, so a divided output keeps its own low half
  assign sub_mask = (div_sel == 2'd0) ? 2'd0 : (div_sel == 2'd1) ? 2'd1 : 2'd3;
  assign realign = use_wc & rise & ((sub_r & sub_mask) == 2'd0);

  // slaved: wrap only after a quarter period of missing input, else jitter would add a glitch edge
  assign hold_per = {1'b0, out_per} + ({1'b0, out_per} >> 2);
  assign wrap = use_wc ? ({1'b0, phase_r} >= hold_per) :
                (phase_r >= out_per - 18'd1);

  // free-running square wave; slaved edges re-align phase to the input
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_r <= '0;
      sub_r <= '0;
      wc_out_r <= 1'b0;
    end else begin
      if (use_wc && rise) begin
        sub_r <= sub_r + 2'd1;
      end
      if (realign) begin
        phase_r <= '0;
        wc_out_r <= 1'b1;
      end else if (wrap) begin
        phase_r <= '0;
        wc_out_r <= 1'b1;
      end else begin
        phase_r <= phase_r + 18'd1;
        if (phase_r >= (out_per >> 1)) begin
          wc_out_r <= 1'b0; // compare, not equality: the period may shrink mid-cycle
        end
      end
    end
  end
  assign wc_out = wc_out_r;

  // fast clock: two toggles per multiple, so 2 x FAST_MULT steps per smoothed reference period
  assign nco_sum = nco_r + (26'(wcs_pkg::FAST_MULT) << 1);
  assign nco_wrap = nco_sum >= {10'h0, ref_per};
  // limitation: above about 48 kHz x 2 the toggle rate saturates at one per clock
  assign nco_sat = {10'h0, ref_per} <= (26'(wcs_pkg::FAST_MULT) << 1);

  // accumulator; fed from the smoothed period so input jitter does not reach it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nco_r <= '0;
      fast_r <= 1'b0;
    end else if (nco_wrap) begin
      nco_r <= nco_sat ? '0 : nco_sum - {10'h0, ref_per};
      fast_r <= ~fast_r;
    end else begin
      nco_r <= nco_sum;
    end
  end
  assign fast_clk_out = fast_r;

  // ===================================================================
  // checks
  AST_SEL_NEEDS_ALL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    use_wc |-> (automatic_sync_mode && pref_wc && det.valid)) else $error("wc used without all conditions");
  AST_LOCK_LED: assert property (@(posedge clk_sys) disable iff (!rst_b)
    word_clock_lock_indicator == det.valid) else $error("lock indicator mismatch");
  AST_FALLBACK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (was_wc_r && !use_wc) |=> lost_r) else $error("no fallback after loss");
  AST_MASTER_RATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!use_wc && !lost_r) |-> ref_per == host_per) else $error("master rate not host rate");
  AST_SS_BAND: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (single_speed && ref_per < wcs_pkg::CNT_W'(wcs_pkg::PER_SS_CYC / 2)) |-> div_sel == 2'd2)
    else $error("single speed divide wrong");
  AST_SLAVE_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (use_wc && rise && div_sel == 2'd0) |=> (wc_out && phase_r == '0)) else $error("output not aligned");
  AST_OUT_TOGGLES: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wrap |=> phase_r == '0) else $error("output phase overrun");
  AST_SLAVE_PER: assert property (@(posedge clk_sys) disable iff (!rst_b)
    use_wc |-> ref_per == avg_per_r) else $error("slave period not from input");

  // selection and source report
  AST_SRC_DISPLAY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (active_sync_source_display == wcs_pkg::WCS_SRC_WC) == use_wc) else $error("source display wrong");
  AST_NO_AUTO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !automatic_sync_mode |-> !use_wc) else $error("wc used without auto mode");
  AST_NO_PREF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pref_wc |-> !use_wc) else $error("wc used without preference");
  AST_DET_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    det.valid |-> (det.period >= wcs_pkg::CNT_W'(wcs_pkg::PER_MIN_CYC) &&
                   det.period <= wcs_pkg::CNT_W'(wcs_pkg::PER_MAX_CYC))) else $error("valid with bad period");

  // fallback
  AST_LOST_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    use_wc |=> !lost_r) else $error("lost flag kept while locked");
  AST_FB_STANDARD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lost_r && !use_wc) |-> (master_per == wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / wcs_pkg::FS_441_HZ) ||
                             master_per == wcs_pkg::CNT_W'(wcs_pkg::CLK_HZ / wcs_pkg::FS_48_HZ)))
    else $error("fallback not a standard rate");

  // single-speed divide
  AST_NO_DIV_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !single_speed |-> div_sel == 2'd0) else $error("divide without option");
  AST_SS_DOUBLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (single_speed && ref_per >= wcs_pkg::CNT_W'(wcs_pkg::PER_SS_CYC / 2) &&
     ref_per < wcs_pkg::CNT_W'(wcs_pkg::PER_SS_CYC)) |-> div_sel == 2'd1) else $error("double not halved");
  AST_SS_SINGLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (single_speed && ref_per >= wcs_pkg::CNT_W'(wcs_pkg::PER_SS_CYC)) |-> div_sel == 2'd0)
    else $error("single rate divided");
  AST_SUB_ADV: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (use_wc && rise) |=> sub_r == $past(sub_r) + 2'd1) else $error("edge counter stuck");

  // output wave
  AST_REALIGN_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    realign |=> (wc_out && phase_r == '0)) else $error("realign missed");
  AST_MASTER_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!use_wc && wrap) |=> (wc_out && phase_r == '0)) else $error("master edge missed");
  AST_FALL_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!realign && !wrap && phase_r >= (out_per >> 1)) |=> !wc_out) else $error("low half missing");

  // fast clock
  AST_FAST_TOGGLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    nco_wrap |=> $changed(fast_clk_out)) else $error("fast clock did not toggle");
  AST_FAST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !nco_wrap |=> $stable(fast_clk_out)) else $error("fast clock extra toggle");

  // register bus
  AST_ZERO_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    psel |-> pready) else $error("wait state inserted");
  AST_BADADR_ERR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (psel && penable && !adr_hit) |-> pslverr) else $error("no error on unmapped");
  AST_BADADR_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_en && !adr_hit) |=> ($stable(ctrl_r) && $stable(rate_r))) else $error("unmapped write landed");
  AST_CTRL_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_ctrl |=> ctrl_r[2:0] == $past(pwdata[2:0])) else $error("control write lost");
  AST_RATE_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_rate |=> rate_r[16:0] == $past(pwdata[16:0])) else $error("rate write lost");
  AST_STAT_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (psel && !penable && !pwrite && sel_stat) |=> prdata[0] == $past(det.valid)) else $error("status read");
  AST_FREQ_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (psel && !penable && !pwrite && sel_freq) |=> prdata[15:0] == $past(ref_per)) else $error("freq read");
  AST_READ_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd_en |=> $stable(prdata)) else $error("read data moved after access");
endmodule // wcs_top

// file: rtl/wcs_pkg.sv
// wcs_pkg: shared constants, register map and carrier types for the word clock sync block
// assumes a 100 MHz system clock and a 32-bit APB register bus
package wcs_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int FS_441_HZ = 44_100;
  localparam int FS_48_HZ = 48_000;
  localparam int FS_32_HZ = 32_000;
  // shortest and longest word clock period accepted, 200 kHz to 28 kHz, covering 32 kHz single to 192 kHz quad
  localparam int PER_MAX_CYC = CLK_HZ / 28_000;
  localparam int PER_MIN_CYC = CLK_HZ / 200_000;
  // single-speed output band boundary, about 50 kHz
  localparam int PER_SS_CYC = CLK_HZ / 50_000;
  // boundary between 44.1 and 48 families, about 46 kHz
  localparam int PER_FAM_CYC = CLK_HZ / 46_000;
  localparam int VALID_PERIODS = 4;
  localparam int CNT_W = 16;
  // regenerated fast clock, 512 x fs, about 22 MHz at 44.1 kHz
  localparam int FAST_MULT = 512;
  localparam int NUM_W = 16;
  localparam logic [NUM_W-1:0] FAST_STEP = 16'h0200;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_RATE = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_FREQ = 8'h0C;
  // control fields
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PREF_WC = 1;
  localparam int CTRL_SS = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RATE_RST = 32'h0000_AC44;

  typedef enum logic [1:0] {WCS_SRC_INT, WCS_SRC_WC} wcs_src_t;

  // status carried out of the detector
  typedef struct packed {
    logic valid;
    logic [CNT_W-1:0] period;
  } wcs_det_t;
endpackage

// file: rtl/wcs_period_det.sv
// wcs_period_det: measures word clock periods and qualifies the signal
// assumes wc_in already synchronised to clk_sys
`timescale 1ns/1ps
module wcs_period_det (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wc_sync,
  output logic rise,
  output wcs_pkg::wcs_det_t det
);
  logic wc_d_r;
  logic [wcs_pkg::CNT_W-1:0] cnt_r;
  logic [2:0] good_r;
  logic in_range;
  logic timeout;

  // =====================================================
  // edge and range decode
  assign rise = wc_sync & ~wc_d_r;
  assign in_range = (cnt_r >= wcs_pkg::CNT_W'(wcs_pkg::PER_MIN_CYC)) &&
                    (cnt_r <= wcs_pkg::CNT_W'(wcs_pkg::PER_MAX_CYC));
  assign timeout = cnt_r > wcs_pkg::CNT_W'(wcs_pkg::PER_MAX_CYC);

  // period counter and qualification, lost on timeout or bad period
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wc_d_r <= 1'b0;
      cnt_r <= '0;
      good_r <= '0;
      det <= '0;
    end else begin
      wc_d_r <= wc_sync;
      if (rise) begin
        cnt_r <= wcs_pkg::CNT_W'(1);
        if (in_range) begin
          det.period <= cnt_r;
          if (good_r == 3'(wcs_pkg::VALID_PERIODS - 1)) begin
            det.valid <= 1'b1;
          end else begin
            good_r <= good_r + 3'h1;
          end
        end else begin
          good_r <= '0;
          det.valid <= 1'b0;
        end
      end else if (timeout) begin
        good_r <= '0;
        det.valid <= 1'b0;
      end else begin
        cnt_r <= cnt_r + wcs_pkg::CNT_W'(1);
      end
    end
  end

  AST_LOST_ON_STOP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    timeout |=> !det.valid) else $error("valid kept after input stopped");
endmodule // wcs_period_det

// file: dv/wcs_wc_master.sv
// wcs_wc_master: behavioural external word clock master on the far side
// assumes clk_sys at 100 MHz; half_cyc sets each half period in clk cycles
`timescale 1ns/1ps
module wcs_wc_master (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [15:0] half_cyc,
  input wire logic signed [1:0] jit,
  output logic wc_line
);
  // ==========================================================
  // square wave source
  logic [15:0] cnt_r;
  // stopped source idles low, no stale edges; jitter only lengthens or shortens the high half
  always_ff @(posedge clk_sys) begin
    if (!run) begin
      cnt_r <= 16'h0000;
      wc_line <= 1'b0;
    end else if (cnt_r == 16'h0000) begin
      wc_line <= ~wc_line;
      cnt_r <= half_cyc - 16'h0001 + (wc_line ? 16'h0000 : 16'(jit));
    end else begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
endmodule // wcs_wc_master

// file: dv/word_clock_sync_control_bench.sv
// word_clock_sync_control_bench: self-checking bench for wcs_top
// assumes the design files under rtl/ and the word clock master model
`timescale 1ns/1ps
module word_clock_sync_control_bench;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, wc_in, wc_out, fast_clk_out, lock;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic run, fo;
  logic [15:0] half_cyc;
  logic signed [1:0] jit;
  int error_cnt, compares, seed, c, i;
  logic [31:0] exp_q[$];
  int tol_q[$];
  logic err_q[$];
  logic rd_q[$];

  wcs_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wc_in(wc_in), .wc_out(wc_out), .fast_clk_out(fast_clk_out), .word_clock_lock_indicator(lock));
  wcs_wc_master far (.clk_sys(clk_sys), .run(run), .half_cyc(half_cyc), .jit(jit), .wc_line(wc_in));

  // ==========================================================
  // clock and random jitter, -1..1 cycle per period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) jit <= 2'($random(seed) % 2);

  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk(input int got, input int e, input int t, input string m);
    compares++;
    if (got > e + t || got < e - t) bad(m);
  endtask

  // ==========================================================
  // completed transfers are compared against the oldest note
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) bad("transfer without note");
      else begin
        compares++;
        if (pslverr !== err_q[0]) bad("pslverr");
        if (rd_q[0] && (^prdata === 1'bx || prdata > exp_q[0] + tol_q[0] || prdata + tol_q[0] < exp_q[0]))
          bad("read data");
        void'(exp_q.pop_front());
        void'(tol_q.pop_front());
        void'(err_q.pop_front());
        void'(rd_q.pop_front());
      end
    end
  end

  // one apb transfer; the note is queued before the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input int t, input logic er);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(d);
    tol_q.push_back(t);
    err_q.push_back(er);
    rd_q.push_back(!wr);
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      bad("pready timeout");
      complete_run();
    end
  endtask

  // cycles from now to the next rising edge of s
  task automatic rise_gap(ref logic s, output int n);
    logic o;
    n = 0;
    do begin
      o = s;
      @(posedge clk_sys);
      #1;
      n++;
    end while (!(o === 1'b0 && s === 1'b1) && n < 20000);
    if (n == 20000) begin
      bad("edge timeout");
      complete_run();
    end
  endtask

  task automatic per(input int e, input int t);
    rise_gap(wc_out, c);
    rise_gap(wc_out, c);
    chk(c, e, t, "wc_out period");
  endtask

  task automatic wait_lock(input logic v);
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (lock !== v && i < 20000);
    chk(i, 10000, 9999, "lock indicator wait");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h806cc691;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_b = 1'b0;
    run = 1'b0;
    half_cyc = 16'h0412;
    error_cnt = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(0, wcs_pkg::ADR_CTRL, wcs_pkg::CTRL_RST, 0, 0);
    apb(0, wcs_pkg::ADR_RATE, wcs_pkg::RATE_RST, 0, 0);
    apb(0, 8'h10, 32'h0000_0000, 0, 1);
    apb(1, 8'h14, 32'h0000_00FF, 0, 1);
    per(wcs_pkg::CLK_HZ / wcs_pkg::FS_441_HZ, 3);
    apb(1, wcs_pkg::ADR_RATE, 32'h0000_BB80, 0, 0);
    per(wcs_pkg::CLK_HZ / wcs_pkg::FS_48_HZ, 3);
    // external master alone runs the system once the device is slaved
    run <= 1'b1;
    apb(1, wcs_pkg::ADR_CTRL, 32'h0000_0001, 0, 0);
    wait_lock(1'b1);
    apb(0, wcs_pkg::ADR_STAT, 32'h0000_0001, 0, 0);
    apb(1, wcs_pkg::ADR_CTRL, 32'h0000_0003, 0, 0);
    repeat (10000) @(posedge clk_sys);
    apb(0, wcs_pkg::ADR_STAT, 32'h0000_0003, 0, 0);
    apb(0, wcs_pkg::ADR_FREQ, 32'd2084, 8, 0);
    per(2084, 4);
    rise_gap(wc_in, c);
    rise_gap(wc_out, c);
    chk(c, 3, 3, "wc_out phase");
    // regenerated fast clock: 512 periods per input period, counted over four
    c = 0;
    rise_gap(wc_in, i);
    for (i = 0; i < 4 * 2084; i++) begin
      fo = fast_clk_out;
      @(posedge clk_sys);
      #1;
      if (fo === 1'b0 && fast_clk_out === 1'b1) c++;
    end
    chk(c, 4 * 512, 8, "fast clock count");
    // double speed input, then single-speed option halves it back
    half_cyc <= 16'h0209;
    repeat (12000) @(posedge clk_sys);
    chk(int'(lock), 1, 0, "lock at double speed");
    per(1042, 4);
    apb(1, wcs_pkg::ADR_CTRL, 32'h0000_0007, 0, 0);
    per(2084, 6);
    // reference lost: master at 48 kHz family
    run <= 1'b0;
    wait_lock(1'b0);
    apb(0, wcs_pkg::ADR_STAT, 32'h0000_0008, 0, 0);
    per(wcs_pkg::CLK_HZ / wcs_pkg::FS_48_HZ, 3);
    complete_run();
  end
endmodule // word_clock_sync_control_bench
